// File: rtl/det_defs.svh
// Register map, limits, reset values and timing for the level detectors
`ifndef DET_DEFS_SVH
`define DET_DEFS_SVH

// ****************************************
// Register indices (byte address is 4x)
// ****************************************
`define IDX_DO_SEL      16'h0A01
`define IDX_RELAY_SEL   16'h0A02
`define IDX_FR_BAND     16'h0A18
`define IDX_AF_TARGET   16'h0A19
`define IDX_AF_BAND     16'h0A1A
`define IDX_ZC_LEVEL    16'h0A1D
`define IDX_ZC_DELAY    16'h0A1E
`define IDX_OC_THR      16'h0A1F
`define IDX_OC_DELAY    16'h0A20
`define IDX_FMAX        16'h010B
`define IDX_STATUS      16'h0A40
`define IDX_MASK        16'h0A41
`define IDX_LIVE        16'h0A42

// ****************************************
// Reset values
// ****************************************
`define RST_DO_SEL      16'h0002
`define RST_RELAY_SEL   16'h0008
`define RST_FR_BAND     16'h0000
`define RST_AF_TARGET   16'h1388
`define RST_AF_BAND     16'h0000
`define RST_ZC_LEVEL    16'h0032
`define RST_ZC_DELAY    16'h000A
`define RST_OC_THR      16'h07D0
`define RST_OC_DELAY    16'h0001
`define RST_FMAX        16'h1388

// ****************************************
// Limits and selector codes
// ****************************************
`define SEL_MAX         16'h0023
`define SEL_ZERO_CUR    16'h0007
`define SEL_FREQ_REACH  16'h0011
`define SEL_ANY_FREQ    16'h0016
`define SEL_OVER_CUR    16'h001E
`define PCT_FREQ_MAX    16'h03E8
`define PCT_CUR_MAX     16'h0BB8
`define PCT_SCALE       1000
`define DELAY_MAX       16'hEA60
`define ZC_DELAY_MIN    16'h0001

// ****************************************
// Timing: delays count in 0.01 s ticks
// ****************************************
`define CLK_HZ          50000000
`define TICK_MS         10
`define TICK_CYCLES     ((`CLK_HZ / 1000) * `TICK_MS)

`endif

// File: rtl/det_pkg.sv
// Types shared by the level detectors and their bench
package det_pkg;

  typedef logic [15:0] word_t;

  // Live measurements, frequency in 0.01 Hz, current in amps units
  typedef struct packed {
    word_t op_freq;
    word_t set_freq;
    word_t out_cur;
    word_t rated_cur;
  } meas_s;

  // One bit per detector, also the status and mask layout
  typedef struct packed {
    logic over_cur;
    logic zero_cur;
    logic any_freq;
    logic freq_reached;
  } det_s;

endpackage : det_pkg

// File: rtl/freq_current_level_detectors.sv
// Frequency and current level detectors with APB registers
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
`include "det_defs.svh"

module freq_current_level_detectors #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [17:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic [31:0]        prdata,
  output logic               pready,
  output logic               pslverr,
  input  det_pkg::meas_s     meas,
  output logic               do_out,
  output logic               relay_out,
  output logic               irq
);
  import det_pkg::*;

  // ****************************************
  // Elaboration checks
  // ****************************************
  if (TICK_CYCLES < 1) begin : g_bad_tick
    $error("TICK_CYCLES must be at least 1");
  end

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [16:0] pct_of(input word_t pct,
                                         input word_t base);
    logic [31:0] prod;
    prod = 32'(pct) * 32'(base);
    prod = prod / `PCT_SCALE;
    // Clamp: 300% of a large rated current overflows 17 bits
    pct_of = (prod > 32'h0001FFFF) ? 17'h1FFFF : prod[16:0];
  endfunction : pct_of

  function automatic logic in_window(input word_t v, input word_t c,
                                     input logic [16:0] w);
    logic [17:0] lo;
    logic [17:0] hi;
    lo = 18'(c) - 18'(w);
    hi = 18'(c) + 18'(w);
    in_window = (w > 17'(c) || 18'(v) >= lo) && 18'(v) <= hi;
  endfunction : in_window

  // ****************************************
  // Registers
  // ****************************************
  word_t       do_sel_r;
  word_t       relay_sel_r;
  word_t       fr_band_r;
  word_t       af_target_r;
  word_t       af_band_r;
  word_t       zc_level_r;
  word_t       zc_delay_r;
  word_t       oc_thr_r;
  word_t       oc_delay_r;
  word_t       fmax_r;
  det_s        status_r;
  det_s        mask_r;
  logic [31:0] tick_cnt_r;
  logic        tick_r;
  word_t       zc_cnt_r;
  word_t       oc_cnt_r;
  det_s        cond_d_r;

  // ****************************************
  // APB decode
  // ****************************************
  wire  [15:0] idx      = paddr[17:2];
  wire         aligned  = paddr[1:0] == 2'b00;
  wire         setup    = psel && !penable;
  wire         wr_en    = psel && penable && pready && pwrite;
  wire  [15:0] wd       = pwdata[15:0];
  wire         hi_zero  = pwdata[31:16] == 16'h0000;
  wire         is_do    = aligned && idx == `IDX_DO_SEL;
  wire         is_rly   = aligned && idx == `IDX_RELAY_SEL;
  wire         is_frb   = aligned && idx == `IDX_FR_BAND;
  wire         is_aft   = aligned && idx == `IDX_AF_TARGET;
  wire         is_afb   = aligned && idx == `IDX_AF_BAND;
  wire         is_zcl   = aligned && idx == `IDX_ZC_LEVEL;
  wire         is_zcd   = aligned && idx == `IDX_ZC_DELAY;
  wire         is_oct   = aligned && idx == `IDX_OC_THR;
  wire         is_ocd   = aligned && idx == `IDX_OC_DELAY;
  wire         is_fmax  = aligned && idx == `IDX_FMAX;
  wire         is_stat  = aligned && idx == `IDX_STATUS;
  wire         is_mask  = aligned && idx == `IDX_MASK;
  wire         is_live  = aligned && idx == `IDX_LIVE;

  // Out-of-range values are refused whole and flagged with pslverr; status and mask writes take pwdata[3:0] unchecked
  wire ok_do   = is_do  && hi_zero && wd <= `SEL_MAX;
  wire ok_rly  = is_rly && hi_zero && wd <= `SEL_MAX;
  wire ok_frb  = is_frb && hi_zero && wd <= `PCT_FREQ_MAX;
  wire ok_aft  = is_aft && hi_zero && wd <= fmax_r;
  wire ok_afb  = is_afb && hi_zero && wd <= `PCT_FREQ_MAX;
  wire ok_zcl  = is_zcl && hi_zero && wd <= `PCT_CUR_MAX;
  wire ok_zcd  = is_zcd && hi_zero && wd >= `ZC_DELAY_MIN
                 && wd <= `DELAY_MAX;
  wire ok_oct  = is_oct && hi_zero && wd <= `PCT_CUR_MAX;
  wire ok_ocd  = is_ocd && hi_zero && wd <= `DELAY_MAX;
  // Fmax may not drop below the stored target
  wire ok_fmax = is_fmax && hi_zero && wd >= af_target_r;
  wire ok_w    = ok_do || ok_rly || ok_frb || ok_aft || ok_afb || ok_zcl
                 || ok_zcd || ok_oct || ok_ocd || ok_fmax || is_stat
                 || is_mask;
  wire mapped  = is_do || is_rly || is_frb || is_aft || is_afb || is_zcl
                 || is_zcd || is_oct || is_ocd || is_fmax || is_stat
                 || is_mask || is_live;
  wire err_nxt = pwrite ? !ok_w : !mapped;

  // ****************************************
  // Detector conditions
  // ****************************************
  wire [16:0] fr_band = pct_of(fr_band_r, fmax_r);
  wire [16:0] af_band = pct_of(af_band_r, fmax_r);
  wire [16:0] zc_lvl  = pct_of(zc_level_r, meas.rated_cur);
  wire [16:0] oc_lvl  = pct_of(oc_thr_r, meas.rated_cur);
  wire fr_cond = in_window(meas.op_freq, meas.set_freq, fr_band);
  wire af_cond = in_window(meas.op_freq, af_target_r, af_band);
  wire zc_cond = 17'(meas.out_cur) <= zc_lvl;
  wire oc_cond = 17'(meas.out_cur) > oc_lvl;
  // Timer compares against delay in ticks; phase of tick adds <1 tick
  wire zc_hit  = zc_cond && zc_cnt_r > zc_delay_r;
  wire oc_hit  = oc_cond && oc_cnt_r > oc_delay_r;
  det_s cond;
  assign cond = '{over_cur: oc_hit, zero_cur: zc_hit,
                  any_freq: af_cond, freq_reached: fr_cond};
  wire [3:0] rise = cond & ~cond_d_r;

  function automatic logic route(input word_t sel, input det_s c);
    unique case (sel)
      `SEL_FREQ_REACH: route = c.freq_reached;
      `SEL_ANY_FREQ:   route = c.any_freq;
      `SEL_ZERO_CUR:   route = c.zero_cur;
      `SEL_OVER_CUR:   route = c.over_cur;
      default:         route = 1'b0;
    endcase
  endfunction : route

  wire [31:0] rd_mux =
      is_do   ? {16'h0000, do_sel_r}    : is_rly  ? {16'h0000, relay_sel_r} :
      is_frb  ? {16'h0000, fr_band_r}   : is_aft  ? {16'h0000, af_target_r} :
      is_afb  ? {16'h0000, af_band_r}   : is_zcl  ? {16'h0000, zc_level_r}  :
      is_zcd  ? {16'h0000, zc_delay_r}  : is_oct  ? {16'h0000, oc_thr_r}    :
      is_ocd  ? {16'h0000, oc_delay_r}  : is_fmax ? {16'h0000, fmax_r}      :
      is_stat ? {28'h0000000, status_r} : is_mask ? {28'h0000000, mask_r}   :
      is_live ? {28'h0000000, cond}     : 32'h00000000;

  // ****************************************
  // APB response, zero wait states
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= setup;
      pslverr <= setup && err_nxt;
      if (setup && !pwrite) begin
        prdata <= rd_mux;
      end
    end
  end

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_sel_r    <= `RST_DO_SEL;
      relay_sel_r <= `RST_RELAY_SEL;
      fr_band_r   <= `RST_FR_BAND;
      af_target_r <= `RST_AF_TARGET;
      af_band_r   <= `RST_AF_BAND;
      zc_level_r  <= `RST_ZC_LEVEL;
      zc_delay_r  <= `RST_ZC_DELAY;
      oc_thr_r    <= `RST_OC_THR;
      oc_delay_r  <= `RST_OC_DELAY;
      fmax_r      <= `RST_FMAX;
      mask_r      <= '0;
    end else if (wr_en) begin
      if (ok_do)   do_sel_r    <= wd;
      if (ok_rly)  relay_sel_r <= wd;
      if (ok_frb)  fr_band_r   <= wd;
      if (ok_aft)  af_target_r <= wd;
      if (ok_afb)  af_band_r   <= wd;
      if (ok_zcl)  zc_level_r  <= wd;
      if (ok_zcd)  zc_delay_r  <= wd;
      if (ok_oct)  oc_thr_r    <= wd;
      if (ok_ocd)  oc_delay_r  <= wd;
      if (ok_fmax) fmax_r      <= wd;
      if (is_mask) mask_r      <= det_s'(pwdata[3:0]);
    end
  end

  // ****************************************
  // Tick divider and persistence timers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_r <= 32'h00000000;
      tick_r     <= 1'b0;
    end else begin
      tick_r     <= tick_cnt_r == 32'(TICK_CYCLES - 1);
      tick_cnt_r <= (tick_cnt_r == 32'(TICK_CYCLES - 1))
                    ? 32'h00000000 : tick_cnt_r + 32'h00000001;
    end
  end

  // Saturate so a long stay never wraps back below the delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      zc_cnt_r <= 16'h0000;
      oc_cnt_r <= 16'h0000;
    end else begin
      if (!zc_cond) zc_cnt_r <= 16'h0000;
      else if (tick_r && zc_cnt_r != 16'hFFFF)
        zc_cnt_r <= zc_cnt_r + 16'h0001;
      if (!oc_cond) oc_cnt_r <= 16'h0000;
      else if (tick_r && oc_cnt_r != 16'hFFFF)
        oc_cnt_r <= oc_cnt_r + 16'h0001;
    end
  end

  // ****************************************
  // Outputs, events and interrupt
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      do_out    <= 1'b0;
      relay_out <= 1'b0;
      cond_d_r  <= '0;
      status_r  <= '0;
      irq       <= 1'b0;
    end else begin
      do_out    <= route(do_sel_r, cond);
      relay_out <= route(relay_sel_r, cond);
      cond_d_r  <= cond;
      // Set wins over a same-cycle write-one-to-clear
      status_r  <= (status_r & ~((wr_en && is_stat) ? pwdata[3:0] : 4'h0))
                   | rise;
      irq       <= |(status_r & mask_r);
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_sel(word_t code);
    do_sel_r == code && $stable(do_sel_r);
  endsequence

  a_do_freq_reach: assert property (
    s_sel(`SEL_FREQ_REACH) |=> do_out == $past(fr_cond))
    else $error("do_out does not follow frequency reached");
  a_do_any_freq: assert property (
    s_sel(`SEL_ANY_FREQ) |=> do_out == $past(af_cond))
    else $error("do_out does not follow any-frequency reached");
  a_fr_inside: assert property (
    (meas.op_freq >= meas.set_freq
     && 17'(meas.op_freq - meas.set_freq) <= fr_band) |-> fr_cond)
    else $error("frequency inside band not detected");
  a_fr_below: assert property (
    (meas.set_freq >= meas.op_freq
     && 17'(meas.set_freq - meas.op_freq) <= fr_band) |-> fr_cond)
    else $error("frequency below set point inside band not detected");
  a_oc_persist: assert property (
    $rose(oc_hit) |-> $past(oc_cond) && oc_cnt_r > oc_delay_r)
    else $error("over-limit asserted without persistence");
  a_zc_persist: assert property (
    $rose(zc_hit) |-> $past(zc_cond) && zc_cnt_r > zc_delay_r)
    else $error("zero current asserted without persistence");
  a_zc_drop: assert property (
    !zc_cond |=> zc_cnt_r == 16'h0000 ##0 !cond_d_r.zero_cur)
    else $error("zero current timer not cleared");
  a_oc_route: assert property (
    relay_sel_r == `SEL_OVER_CUR && !oc_cond ##1
    relay_sel_r == `SEL_OVER_CUR |-> !relay_out)
    else $error("over-limit output not dropped");
  a_target_limit: assert property (
    wr_en && is_aft && wd > fmax_r |=> $stable(af_target_r))
    else $error("target above fmax accepted");
  a_zc_delay_min: assert property (
    wr_en && is_zcd && wd == 16'h0000 |-> pslverr ##1 $stable(zc_delay_r))
    else $error("zero-current delay of zero accepted");
  a_oc_thr_limit: assert property (
    wr_en && is_oct && wd > `PCT_CUR_MAX |=> $stable(oc_thr_r))
    else $error("over-limit threshold above range accepted");
  a_no_hyst: assert property (
    $stable(meas) && $stable(af_target_r) && $stable(af_band_r)
    && $stable(fmax_r) |-> $stable(af_cond))
    else $error("any-frequency condition has memory");

endmodule : freq_current_level_detectors

// File: tb/tb_freq_current_level_detectors.sv
// Self-checking bench for the frequency and current level detectors
`timescale 1ns/1ps
`include "det_defs.svh"

module tb_freq_current_level_detectors;
  import det_pkg::*;

  localparam int TICK = 10;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [17:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  meas_s       meas;
  logic        do_out;
  logic        relay_out;
  logic        irq;
  logic [31:0] rdata_q;
  logic        err_q;
  int          n_checks;
  int          n_mismatch;

  freq_current_level_detectors #(
    .TICK_CYCLES(TICK)
  ) freq_current_level_detectors_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .meas(meas), .do_out(do_out),
    .relay_out(relay_out), .irq(irq)
  );

  always #10 pclk = ~pclk;

  // ****************************************
  // Compare and report
  // ****************************************
  task automatic chk_word(input string what, input logic [31:0] e,
                          input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string what, input logic e, input logic g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %b seen %b", what, e, g);
    end
  endtask : chk_bit

  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : tally_and_finish

  // ****************************************
  // APB master
  // ****************************************
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [17:0] a, input logic [31:0] d);
    int guard;
    guard = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      guard++;
    end while (pready !== 1'b1 && guard < 50);
    if (guard == 50)
      n_mismatch++;
    rdata_q = prdata;
    err_q   = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [15:0] idx, input logic [31:0] d,
                    input logic e);
    apb(1'b1, {idx, 2'b00}, d);
    chk_bit("write error flag", e, err_q);
  endtask : wr

  task automatic rd(input logic [15:0] idx, input logic [31:0] x,
                    input logic e);
    apb(1'b0, {idx, 2'b00}, 32'h0);
    chk_word("read data", x, rdata_q);
    chk_bit("read error flag", e, err_q);
  endtask : rd

  // Refused write must leave the old value in place
  task automatic refuse(input logic [15:0] idx, input logic [31:0] bad,
                        input logic [31:0] keep);
    wr(idx, bad, 1'b1);
    rd(idx, keep, 1'b0);
  endtask : refuse

  // ****************************************
  // Measurement drive and output checks
  // ****************************************
  task automatic outs(input int n, input logic e_do, input logic e_rl);
    repeat (n) @(posedge pclk);
    #1;
    chk_bit("do_out", e_do, do_out);
    chk_bit("relay_out", e_rl, relay_out);
  endtask : outs

  // Rated current fixed at 1000, so percent levels map one to one
  task automatic step(input logic [15:0] op, input logic [15:0] sf,
                      input logic [15:0] cur, input logic e_do,
                      input logic e_rl);
    @(posedge pclk);
    meas <= '{op_freq: op, set_freq: sf, out_cur: cur, rated_cur: 16'h03E8};
    outs(3, e_do, e_rl);
  endtask : step

  task automatic chk_irq(input logic e);
    repeat (2) @(posedge pclk);
    #1;
    chk_bit("irq", e, irq);
  endtask : chk_irq

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    tally_and_finish();
  end

  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 18'h0; pwdata = 32'h0; n_checks = 0; n_mismatch = 0;
    // Neutral levels: no detector true out of reset
    meas = '{op_freq: 16'h03E8, set_freq: 16'h0BB8, out_cur: 16'h01F4,
             rated_cur: 16'h03E8};
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(`IDX_DO_SEL, 32'h2, 1'b0);
    rd(`IDX_RELAY_SEL, 32'h8, 1'b0);
    rd(`IDX_FR_BAND, 32'h0, 1'b0);
    rd(`IDX_AF_TARGET, 32'h1388, 1'b0);
    rd(`IDX_AF_BAND, 32'h0, 1'b0);
    rd(`IDX_ZC_LEVEL, 32'h32, 1'b0);
    rd(`IDX_ZC_DELAY, 32'hA, 1'b0);
    rd(`IDX_OC_THR, 32'h7D0, 1'b0);
    rd(`IDX_OC_DELAY, 32'h1, 1'b0);
    rd(`IDX_STATUS, 32'h0, 1'b0);
    rd(`IDX_MASK, 32'h0, 1'b0);
    rd(16'h0A03, 32'h0, 1'b1);
    apb(1'b0, {`IDX_DO_SEL, 2'b10}, 32'h0);
    chk_bit("misaligned error flag", 1'b1, err_q);
    $display("test reset values finished");
    refuse(`IDX_AF_TARGET, 32'h1389, 32'h1388);
    refuse(`IDX_FMAX, 32'h1387, 32'h1388);
    refuse(`IDX_FR_BAND, 32'h3E9, 32'h0);
    refuse(`IDX_AF_BAND, 32'h3E9, 32'h0);
    refuse(`IDX_ZC_LEVEL, 32'hBB9, 32'h32);
    refuse(`IDX_ZC_DELAY, 32'h0, 32'hA);
    refuse(`IDX_ZC_DELAY, 32'hEA61, 32'hA);
    refuse(`IDX_OC_THR, 32'hBB9, 32'h7D0);
    refuse(`IDX_OC_DELAY, 32'hEA61, 32'h1);
    refuse(`IDX_DO_SEL, 32'h24, 32'h2);
    refuse(`IDX_DO_SEL, 32'h10011, 32'h2);
    wr(`IDX_ZC_LEVEL, 32'hBB8, 1'b0);
    wr(`IDX_ZC_DELAY, 32'hEA60, 1'b0);
    wr(`IDX_OC_DELAY, 32'h0, 1'b0);
    rd(`IDX_OC_DELAY, 32'h0, 1'b0);
    wr(`IDX_OC_DELAY, 32'h1, 1'b0);
    wr(`IDX_ZC_LEVEL, 32'h32, 1'b0);
    $display("test refused writes finished");
    // Band 10% of 50.00Hz is 5.00Hz around 20.00Hz
    wr(`IDX_DO_SEL, 32'h11, 1'b0);
    wr(`IDX_FR_BAND, 32'h64, 1'b0);
    step(16'h09C4, 16'h07D0, 16'h01F4, 1'b1, 1'b0);
    step(16'h09C5, 16'h07D0, 16'h01F4, 1'b0, 1'b0);
    step(16'h05DC, 16'h07D0, 16'h01F4, 1'b1, 1'b0);
    rd(`IDX_LIVE, 32'h1, 1'b0);
    step(16'h05DB, 16'h07D0, 16'h01F4, 1'b0, 1'b0);
    $display("test frequency reached finished");
    // Band 2% of 50.00Hz is 1.00Hz around the target
    wr(`IDX_RELAY_SEL, 32'h16, 1'b0);
    wr(`IDX_AF_BAND, 32'h14, 1'b0);
    step(16'h1324, 16'h07D0, 16'h01F4, 1'b0, 1'b1);
    step(16'h1323, 16'h07D0, 16'h01F4, 1'b0, 1'b0);
    step(16'h13EC, 16'h07D0, 16'h01F4, 1'b0, 1'b1);
    step(16'h13ED, 16'h07D0, 16'h01F4, 1'b0, 1'b0);
    wr(`IDX_AF_TARGET, 32'hFA0, 1'b0);
    step(16'h0F3C, 16'h07D0, 16'h01F4, 1'b0, 1'b1);
    wr(`IDX_DO_SEL, 32'h16, 1'b0);
    outs(2, 1'b1, 1'b1);
    $display("test any frequency finished");
    // Delay of 2 ticks: output needs three ticks of persistence
    wr(`IDX_RELAY_SEL, 32'h1E, 1'b0);
    wr(`IDX_DO_SEL, 32'h7, 1'b0);
    wr(`IDX_ZC_DELAY, 32'h2, 1'b0);
    step(16'h03E8, 16'h0BB8, 16'h0032, 1'b0, 1'b0);
    outs(12, 1'b0, 1'b0);
    outs(25, 1'b1, 1'b0);
    wr(`IDX_DO_SEL, 32'hF, 1'b0);
    outs(2, 1'b0, 1'b0);
    wr(`IDX_DO_SEL, 32'h7, 1'b0);
    outs(2, 1'b1, 1'b0);
    step(16'h03E8, 16'h0BB8, 16'h0033, 1'b0, 1'b0);
    step(16'h03E8, 16'h0BB8, 16'h0032, 1'b0, 1'b0);
    outs(12, 1'b0, 1'b0);
    $display("test zero current finished");
    step(16'h03E8, 16'h0BB8, 16'h07D0, 1'b0, 1'b0);
    outs(37, 1'b0, 1'b0);
    step(16'h03E8, 16'h0BB8, 16'h07D1, 1'b0, 1'b0);
    outs(27, 1'b0, 1'b1);
    step(16'h03E8, 16'h0BB8, 16'h07D0, 1'b0, 1'b0);
    $display("test over current finished");
    rd(`IDX_STATUS, 32'hF, 1'b0);
    chk_irq(1'b0);
    wr(`IDX_MASK, 32'h4, 1'b0);
    chk_irq(1'b1);
    wr(`IDX_MASK, 32'h0, 1'b0);
    chk_irq(1'b0);
    wr(`IDX_MASK, 32'h4, 1'b0);
    wr(`IDX_STATUS, 32'h1, 1'b0);
    rd(`IDX_STATUS, 32'hE, 1'b0);
    chk_irq(1'b1);
    wr(`IDX_STATUS, 32'hE, 1'b0);
    rd(`IDX_STATUS, 32'h0, 1'b0);
    chk_irq(1'b0);
    $display("test interrupts finished");
    tally_and_finish();
  end

endmodule : tb_freq_current_level_detectors
